// ---- rtl/clock_divider.sv ----
// Even divider producing a square clock level from the system clock
`timescale 1ns/1ps
module clock_divider #(
  parameter int DIV = 2
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  output logic      o_clk
);
  localparam int          HALF = DIV / 2;
  localparam logic [7:0]  LAST = 8'(HALF - 1);

  logic [7:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 8'h00;
      o_clk <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= 8'h00;
      o_clk <= ~o_clk;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// ---- rtl/cpu_bus_if.sv ----
// Processor status/address bus between the processor end and the controller
`timescale 1ns/1ps
interface cpu_bus_if;
  logic        status_bit0_n;
  logic        status_bit1_n;
  logic        mem_io;
  logic        high_byte_enable_n;
  logic [23:0] addr;
  logic        speed_select_data_bit;
  logic        hold_acknowledge;
  logic        ready_n;
  logic        processor_clock;

  modport device (
    input  status_bit0_n, status_bit1_n, mem_io, high_byte_enable_n, addr,
    input  speed_select_data_bit, hold_acknowledge,
    output ready_n, processor_clock
  );

  modport host (
    output status_bit0_n, status_bit1_n, mem_io, high_byte_enable_n, addr,
    output speed_select_data_bit, hold_acknowledge,
    input  ready_n, processor_clock
  );
endinterface

// ---- rtl/cpu_ctrl_device.sv ----
// Controller end: clocks, command decode, wait states, DRAM and ROM control
`timescale 1ns/1ps
module cpu_ctrl_device (
  input  wire logic      i_clk,
  input  wire logic      i_rstn,
  cpu_bus_if.device      bus,
  input  wire logic      i_mem16_n,
  input  wire logic      i_mem_config_bit0,
  input  wire logic      i_mem_config_bit1,
  output logic           o_fast_mode,
  output logic           o_dram_ctrl_clock,
  output logic           o_bus_clock,
  output logic           o_dma_clock,
  output logic           o_video_osc_clock,
  output logic           o_sound_clock,
  output logic           o_timer_clock,
  output logic           o_ale,
  output logic           o_int_ack_n,
  output logic           o_io_read_n,
  output logic           o_io_write_n,
  output logic           o_mem_read_n,
  output logic           o_memory_write_cmd_n,
  output logic           o_halt,
  output logic           o_cmd_oe,
  output logic [1:0]     o_width,
  output logic           o_dram_cycle_active,
  output logic           o_row_strobe_bank0_n,
  output logic           o_row_strobe_bank1_n,
  output logic           o_row_strobe_bank2_n,
  output logic           o_mux_column,
  output logic           o_col_strobe_low_n,
  output logic           o_col_strobe_high_n,
  output logic           o_dram_write_enable0_n,
  output logic           o_dram_write_enable1_n,
  output logic           o_boot_rom_select_n
);

  typedef enum logic [2:0] {D_IDLE, D_ROW_WAIT, D_ROW, D_COL, D_CAS} dram_state_t;

  // ----------------------------------------
  // Processor clock with glitch-free speed switch
  // ----------------------------------------
  logic       fast_req_r;
  logic       pclk_r;
  logic [3:0] ph_cnt_r;
  logic [3:0] half;
  logic       p_tick;
  logic       p_rise;
  logic       p_fall;

  assign half   = o_fast_mode ? cpu_ctrl_pkg::FAST_HALF : cpu_ctrl_pkg::SLOW_HALF;
  assign p_tick = (ph_cnt_r == 4'(half - 4'h1));
  assign p_rise = p_tick & ~pclk_r;
  assign p_fall = p_tick & pclk_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ph_cnt_r <= 4'h0;
      pclk_r   <= 1'b0;
    end else begin
      ph_cnt_r <= p_tick ? 4'h0 : ph_cnt_r + 4'h1;
      pclk_r   <= pclk_r ^ p_tick;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fast_mode <= 1'b1;
    end else if (p_fall) begin
      o_fast_mode <= fast_req_r;
    end
  end

  assign bus.processor_clock = pclk_r;
  assign o_dram_ctrl_clock   = pclk_r;

  // ----------------------------------------
  // Bus and DMA clocks
  // ----------------------------------------
  logic run_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_r       <= 1'b0;
      o_bus_clock <= 1'b0;
      o_dma_clock <= 1'b0;
    end else if (p_fall && (run_r || !bus.status_bit1_n)) begin
      run_r       <= 1'b1;
      o_bus_clock <= ~o_bus_clock;
      if (!o_bus_clock) begin
        o_dma_clock <= ~o_dma_clock;
      end
    end
  end

  // ----------------------------------------
  // Oscillator dividers
  // ----------------------------------------
  logic [2:0] osc;

  function automatic int div_of(input int idx);
    case (idx)
      0:       div_of = cpu_ctrl_pkg::DIV_VIDEO;
      1:       div_of = cpu_ctrl_pkg::DIV_SOUND;
      default: div_of = cpu_ctrl_pkg::DIV_TIMER;
    endcase
  endfunction

  for (genvar g = 0; g < 3; g++) begin : g_osc
    clock_divider #(.DIV(div_of(g))) u_div (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .o_clk  (osc[g])
    );
  end

  assign o_video_osc_clock = osc[0];
  assign o_sound_clock     = osc[1];
  assign o_timer_clock     = osc[2];

  // ----------------------------------------
  // Cycle start and decode
  // ----------------------------------------
  logic [2:0]  code;
  logic        stat_idle;
  logic        prev_idle_r;
  logic        ale;
  logic        cyc_r;
  logic        cyc_end;
  logic [2:0]  code_r;
  logic [15:0] port_r;
  logic [3:0]  wcnt_r;
  logic [3:0]  waits_r;
  logic        bank0_hit;
  logic        bank1_hit;
  logic        rom_hit;
  logic        bank0_r;
  logic        bank1_r;
  logic        mem_rw;

  assign code      = {bus.mem_io, bus.status_bit1_n, bus.status_bit0_n};
  assign stat_idle = (code == cpu_ctrl_pkg::CODE_IDLE0) || (code == cpu_ctrl_pkg::CODE_IDLE1);
  assign ale       = prev_idle_r && !stat_idle && !cyc_r;
  assign mem_rw    = (code == cpu_ctrl_pkg::CODE_MEM_RD) || (code == cpu_ctrl_pkg::CODE_MEM_WR);
  assign cyc_end   = cyc_r && p_rise && (wcnt_r == 4'(waits_r + cpu_ctrl_pkg::WAIT_BASE));

  assign bank0_hit = i_mem_config_bit0 && (bus.addr >= cpu_ctrl_pkg::BANK0_LO)
                     && (bus.addr <= cpu_ctrl_pkg::BANK0_HI);
  assign bank1_hit = i_mem_config_bit1 && i_mem_config_bit0
                     && (bus.addr >= cpu_ctrl_pkg::BANK1_LO)
                     && (bus.addr <= cpu_ctrl_pkg::BANK1_HI);
  assign rom_hit   = ((bus.addr >= cpu_ctrl_pkg::ROM0_LO) && (bus.addr <= cpu_ctrl_pkg::ROM0_HI))
                  || ((bus.addr >= cpu_ctrl_pkg::ROM1_LO) && (bus.addr <= cpu_ctrl_pkg::ROM1_HI))
                  || (bus.addr >= cpu_ctrl_pkg::ROM2_LO);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_idle_r <= 1'b1;
      o_ale       <= 1'b0;
    end else begin
      prev_idle_r <= stat_idle;
      o_ale       <= ale;
    end
  end

  // Latched cycle attributes, held for the whole cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cyc_r   <= 1'b0;
      code_r  <= cpu_ctrl_pkg::CODE_IDLE1;
      port_r  <= 16'h0000;
      waits_r <= 4'h0;
      bank0_r <= 1'b0;
      bank1_r <= 1'b0;
      o_width <= cpu_ctrl_pkg::WIDTH_NONE;
    end else if (ale) begin
      cyc_r   <= 1'b1;
      code_r  <= code;
      port_r  <= bus.addr[15:0];
      o_width <= {bus.high_byte_enable_n, bus.addr[0]};
      bank0_r <= mem_rw && bank0_hit;
      bank1_r <= mem_rw && bank1_hit;
      if (bus.mem_io && !i_mem16_n) begin
        waits_r <= cpu_ctrl_pkg::WAIT_16;
      end else if (o_fast_mode) begin
        waits_r <= cpu_ctrl_pkg::WAIT_8_FAST;
      end else begin
        waits_r <= cpu_ctrl_pkg::WAIT_8_SLOW;
      end
    end else if (cyc_end) begin
      cyc_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Wait counting and ready
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wcnt_r      <= 4'h0;
      bus.ready_n <= 1'b1;
    end else begin
      bus.ready_n <= ~cyc_end;
      if (ale) begin
        wcnt_r <= 4'h0;
      end else if (cyc_r && p_rise) begin
        wcnt_r <= wcnt_r + 4'h1;
      end
    end
  end

  // Speed request captured as the speed-port write completes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fast_req_r <= 1'b1;
    end else if (cyc_end && code_r == cpu_ctrl_pkg::CODE_IO_WR
                 && port_r == cpu_ctrl_pkg::SPEED_PORT) begin
      fast_req_r <= bus.speed_select_data_bit;
    end
  end

  // ----------------------------------------
  // Commands
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_int_ack_n            <= 1'b1;
      o_io_read_n            <= 1'b1;
      o_io_write_n           <= 1'b1;
      o_mem_read_n           <= 1'b1;
      o_memory_write_cmd_n   <= 1'b1;
      o_dram_write_enable0_n <= 1'b1;
      o_dram_write_enable1_n <= 1'b1;
      o_halt                 <= 1'b0;
      o_cmd_oe               <= 1'b0;
    end else begin
      o_cmd_oe <= ~bus.hold_acknowledge;
      if (ale) begin
        o_int_ack_n            <= ~(code == cpu_ctrl_pkg::CODE_INTA);
        o_io_read_n            <= ~(code == cpu_ctrl_pkg::CODE_IO_RD);
        o_io_write_n           <= ~(code == cpu_ctrl_pkg::CODE_IO_WR);
        o_mem_read_n           <= ~(code == cpu_ctrl_pkg::CODE_MEM_RD);
        o_memory_write_cmd_n   <= ~(code == cpu_ctrl_pkg::CODE_MEM_WR);
        o_dram_write_enable0_n <= ~(code == cpu_ctrl_pkg::CODE_MEM_WR);
        o_dram_write_enable1_n <= ~(code == cpu_ctrl_pkg::CODE_MEM_WR);
        o_halt                 <= (code == cpu_ctrl_pkg::CODE_HALT);
      end else if (cyc_end) begin
        o_int_ack_n            <= 1'b1;
        o_io_read_n            <= 1'b1;
        o_io_write_n           <= 1'b1;
        o_mem_read_n           <= 1'b1;
        o_memory_write_cmd_n   <= 1'b1;
        o_dram_write_enable0_n <= 1'b1;
        o_dram_write_enable1_n <= 1'b1;
        o_halt                 <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Boot ROM select
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_boot_rom_select_n <= 1'b1;
    end else if (ale) begin
      o_boot_rom_select_n <= ~(rom_hit && !bus.hold_acknowledge);
    end else if (cyc_end) begin
      o_boot_rom_select_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // DRAM strobe sequencer
  // ----------------------------------------
  dram_state_t dstate_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dstate_r             <= D_IDLE;
      o_dram_cycle_active  <= 1'b0;
      o_row_strobe_bank0_n <= 1'b1;
      o_row_strobe_bank1_n <= 1'b1;
      o_row_strobe_bank2_n <= 1'b1;
      o_mux_column         <= 1'b0;
      o_col_strobe_low_n   <= 1'b1;
      o_col_strobe_high_n  <= 1'b1;
    end else if (cyc_end) begin
      dstate_r             <= D_IDLE;
      o_dram_cycle_active  <= 1'b0;
      o_row_strobe_bank0_n <= 1'b1;
      o_row_strobe_bank1_n <= 1'b1;
      o_mux_column         <= 1'b0;
      o_col_strobe_low_n   <= 1'b1;
      o_col_strobe_high_n  <= 1'b1;
    end else begin
      case (dstate_r)
        D_IDLE: begin
          if (cyc_r && (bank0_r || bank1_r) && o_width != cpu_ctrl_pkg::WIDTH_NONE) begin
            dstate_r            <= D_ROW_WAIT;
            o_dram_cycle_active <= 1'b1;
          end
        end
        D_ROW_WAIT: begin
          if (p_fall) begin
            dstate_r             <= D_ROW;
            o_row_strobe_bank0_n <= ~bank0_r;
            o_row_strobe_bank1_n <= ~bank1_r;
          end
        end
        D_ROW: begin
          if (p_rise) begin
            dstate_r     <= D_COL;
            o_mux_column <= 1'b1;
          end
        end
        D_COL: begin
          if (p_rise) begin
            dstate_r            <= D_CAS;
            o_col_strobe_low_n  <= o_width[0];
            o_col_strobe_high_n <= ~o_width[0] && o_width[1];
          end
        end
        D_CAS: begin
          dstate_r <= D_CAS;
        end
        default: begin
          dstate_r <= D_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- rtl/cpu_ctrl_host.sv ----
// Processor end: issues status-coded bus cycles and waits for ready
`timescale 1ns/1ps
module cpu_ctrl_host (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  cpu_bus_if.host          bus,
  input  wire logic        i_start,
  input  wire logic [2:0]  i_code,
  input  wire logic [23:0] i_addr,
  input  wire logic        i_high_byte_enable_n,
  input  wire logic        i_speed_select_data_bit,
  input  wire logic        i_hold_acknowledge,
  output logic             o_busy,
  output logic             o_done
);

  typedef enum logic [1:0] {H_IDLE, H_ALIGN, H_STATUS, H_WAIT} host_state_t;

  host_state_t state_r;
  logic        pclk_prev_r;
  logic        p_rise;

  assign p_rise = bus.processor_clock && !pclk_prev_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pclk_prev_r          <= 1'b0;
      bus.hold_acknowledge <= 1'b0;
    end else begin
      pclk_prev_r          <= bus.processor_clock;
      bus.hold_acknowledge <= i_hold_acknowledge;
    end
  end

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r                   <= H_IDLE;
      bus.mem_io                <= 1'b1;
      bus.status_bit1_n         <= 1'b1;
      bus.status_bit0_n         <= 1'b1;
      bus.addr                  <= 24'h000000;
      bus.high_byte_enable_n    <= 1'b1;
      bus.speed_select_data_bit <= 1'b0;
      o_busy                    <= 1'b0;
      o_done                    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        H_IDLE: begin
          if (i_start) begin
            state_r                   <= H_ALIGN;
            o_busy                    <= 1'b1;
            bus.addr                  <= i_addr;
            bus.high_byte_enable_n    <= i_high_byte_enable_n;
            bus.speed_select_data_bit <= i_speed_select_data_bit;
          end
        end
        H_ALIGN: begin
          if (p_rise) begin
            state_r           <= H_STATUS;
            bus.mem_io        <= i_code[2];
            bus.status_bit1_n <= i_code[1];
            bus.status_bit0_n <= i_code[0];
          end
        end
        H_STATUS: begin
          if (p_rise) begin
            state_r           <= H_WAIT;
            bus.status_bit1_n <= 1'b1;
            bus.status_bit0_n <= 1'b1;
          end
        end
        H_WAIT: begin
          if (!bus.ready_n) begin
            state_r <= H_IDLE;
            o_busy  <= 1'b0;
            o_done  <= 1'b1;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- rtl/cpu_ctrl_pkg.sv ----
// Shared constants and types for the processor bus clock and memory controller
package cpu_ctrl_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int          CLK_HZ     = 20_000_000;
  localparam logic [3:0]  FAST_HALF  = 4'h1;
  localparam logic [3:0]  SLOW_HALF  = 4'h2;
  localparam int          DIV_VIDEO  = 2;
  localparam int          DIV_SOUND  = 8;
  localparam int          DIV_TIMER  = 24;

  // ----------------------------------------
  // Wait states
  // ----------------------------------------
  localparam logic [3:0]  WAIT_8_FAST = 4'h4;
  localparam logic [3:0]  WAIT_8_SLOW = 4'h2;
  localparam logic [3:0]  WAIT_16     = 4'h1;
  localparam logic [3:0]  WAIT_BASE   = 4'h2;

  // ----------------------------------------
  // Speed port
  // ----------------------------------------
  localparam logic [15:0] SPEED_PORT  = 16'h0062;

  // ----------------------------------------
  // Status codes {mem_io, s1_n, s0_n}
  // ----------------------------------------
  localparam logic [2:0]  CODE_INTA   = 3'h0;
  localparam logic [2:0]  CODE_IO_RD  = 3'h1;
  localparam logic [2:0]  CODE_IO_WR  = 3'h2;
  localparam logic [2:0]  CODE_IDLE0  = 3'h3;
  localparam logic [2:0]  CODE_HALT   = 3'h4;
  localparam logic [2:0]  CODE_MEM_RD = 3'h5;
  localparam logic [2:0]  CODE_MEM_WR = 3'h6;
  localparam logic [2:0]  CODE_IDLE1  = 3'h7;

  // ----------------------------------------
  // Memory map
  // ----------------------------------------
  localparam logic [23:0] BANK0_LO = 24'h000000;
  localparam logic [23:0] BANK0_HI = 24'h07FFFF;
  localparam logic [23:0] BANK1_LO = 24'h080000;
  localparam logic [23:0] BANK1_HI = 24'h09FFFF;
  localparam logic [23:0] ROM0_LO  = 24'h0E0000;
  localparam logic [23:0] ROM0_HI  = 24'h0FFFFF;
  localparam logic [23:0] ROM1_LO  = 24'hEE0000;
  localparam logic [23:0] ROM1_HI  = 24'hEFFFFF;
  localparam logic [23:0] ROM2_LO  = 24'hFE0000;
  localparam logic [23:0] ROM2_HI  = 24'hFFFFFF;

  // ----------------------------------------
  // Transfer width {high_byte_enable_n, a0}
  // ----------------------------------------
  typedef enum logic [1:0] {
    WIDTH_WORD = 2'h0,
    WIDTH_HIGH = 2'h1,
    WIDTH_LOW  = 2'h2,
    WIDTH_NONE = 2'h3
  } width_t;

endpackage

// ---- tb/cpu_bus_clock_and_memory_control_asserts.sv ----
// Checker for the status bus between the processor end and the controller
`timescale 1ns/1ps
module cpu_bus_clock_and_memory_control_asserts (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        status_bit0_n,
  input wire logic        status_bit1_n,
  input wire logic        mem_io,
  input wire logic        high_byte_enable_n,
  input wire logic [23:0] addr,
  input wire logic        speed_select_data_bit,
  input wire logic        hold_acknowledge,
  input wire logic        ready_n,
  input wire logic        processor_clock
);
  // ----------------------------------------
  // Cycle tracking
  // ----------------------------------------
  logic       idle;
  logic       open_r;
  logic       run_r;
  logic [2:0] ph_r;
  logic [3:0] rise_r;
  assign idle = status_bit1_n & status_bit0_n;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) open_r <= 1'b0;
    else if (!ready_n) open_r <= 1'b0;
    else if (!idle) open_r <= 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_r <= 1'b0;
      ph_r  <= 3'h0;
    end else if ($changed(processor_clock)) begin
      run_r <= 1'b1;
      ph_r  <= 3'h0;
    end else if (ph_r != 3'h7) ph_r <= ph_r + 3'h1;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) rise_r <= 4'h0;
    else if (!idle && !open_r) rise_r <= 4'h0;
    else if ($rose(processor_clock) && rise_r != 4'hF) rise_r <= rise_r + 4'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_ready_one_pulse: assert property (!ready_n |=> ready_n)
    else $error("ready held longer than one cycle");
  a_ready_in_cycle: assert property (!ready_n |-> open_r)
    else $error("ready without an open cycle");
  a_status_brief: assert property (!idle |-> ##[1:5] idle)
    else $error("status not returned to idle");
  a_no_overlap: assert property ($fell(idle) |-> !open_r)
    else $error("new status while cycle open");
  a_ready_bound: assert property ($fell(idle) && !open_r |-> ##[3:40] !ready_n)
    else $error("cycle not answered in time");
  a_wait_rises: assert property (!ready_n |-> rise_r >= 4'h2 && rise_r <= 4'h7)
    else $error("ready at wrong clock count");
  a_attr_held: assert property (open_r && ready_n |->
    $stable({addr, high_byte_enable_n, mem_io, hold_acknowledge}))
    else $error("cycle attributes changed");
  a_phase_len: assert property (run_r |-> ph_r <= 3'h1)
    else $error("processor clock phase too long");
  c_ready: cover property (!ready_n);
  c_hold: cover property (open_r && hold_acknowledge);
  c_slow: cover property (run_r && ph_r == 3'h1);
endmodule

// ---- tb/cpu_bus_clock_and_memory_control_test.sv ----
// Testbench joining the processor end and the controller end
`timescale 1ns/1ps
module cpu_bus_clock_and_memory_control_test;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_start = 1'b0;
  logic [2:0]  i_code = 3'h7;
  logic [23:0] i_addr = 24'h000000;
  logic        hbe_n = 1'b1;
  logic        spd = 1'b1;
  logic        hlda = 1'b0;
  logic        m16_n = 1'b1;
  logic [1:0]  cfg = 2'h3;
  logic        o_done, fast, bclk, dclk, vclk, sclk, tclk, halt, oe, mux, pclk;
  logic        inta_n, ior_n, iow_n, memr_n, memory_write_cmd_n_n, row0_n, row1_n, row2_n;
  logic        col_strobe_low_n_n, col_strobe_high_n_n, we0_n, we1_n, rom_n;
  logic        dcc, alep, mcyc;
  logic [1:0]  wid_o;
  logic [1:0]  wid;
  logic [14:0] seen;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          rises, tr, tm, tc, r8, r16;
  logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic [24:0] wt [4] = '{25'h0000200 | 25'h1000000, 25'h0000201, 25'h0080000, 25'h009FFFF};
  logic [23:0] rt [4] = '{24'h0E0000, 24'hEEFFFE, 24'hFE0010, 24'h0D0000};
  cpu_bus_if cpu_bus_if_inst ();
  assign pclk = cpu_bus_if_inst.processor_clock;
  cpu_ctrl_host cpu_ctrl_host_inst (.i_clk(i_clk), .i_rstn(i_rstn), .bus(cpu_bus_if_inst),
    .i_start(i_start), .i_code(i_code), .i_addr(i_addr), .i_high_byte_enable_n(hbe_n),
    .i_speed_select_data_bit(spd), .i_hold_acknowledge(hlda), .o_busy(), .o_done(o_done));
  cpu_ctrl_device cpu_ctrl_device_inst (.i_clk(i_clk), .i_rstn(i_rstn), .bus(cpu_bus_if_inst),
    .i_mem16_n(m16_n), .i_mem_config_bit0(cfg[0]), .i_mem_config_bit1(cfg[1]),
    .o_fast_mode(fast), .o_dram_ctrl_clock(dcc), .o_bus_clock(bclk), .o_dma_clock(dclk),
    .o_video_osc_clock(vclk), .o_sound_clock(sclk), .o_timer_clock(tclk), .o_ale(alep),
    .o_int_ack_n(inta_n), .o_io_read_n(ior_n), .o_io_write_n(iow_n), .o_mem_read_n(memr_n),
    .o_memory_write_cmd_n(memory_write_cmd_n_n), .o_halt(halt), .o_cmd_oe(oe), .o_width(wid_o),
    .o_dram_cycle_active(mcyc), .o_row_strobe_bank0_n(row0_n), .o_row_strobe_bank1_n(row1_n),
    .o_row_strobe_bank2_n(row2_n), .o_mux_column(mux), .o_col_strobe_low_n(col_strobe_low_n_n),
    .o_col_strobe_high_n(col_strobe_high_n_n), .o_dram_write_enable0_n(we0_n),
    .o_dram_write_enable1_n(we1_n), .o_boot_rom_select_n(rom_n));
  cpu_bus_clock_and_memory_control_asserts asserts_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .status_bit0_n(cpu_bus_if_inst.status_bit0_n),
    .status_bit1_n(cpu_bus_if_inst.status_bit1_n), .mem_io(cpu_bus_if_inst.mem_io),
    .high_byte_enable_n(cpu_bus_if_inst.high_byte_enable_n), .addr(cpu_bus_if_inst.addr),
    .speed_select_data_bit(cpu_bus_if_inst.speed_select_data_bit),
    .hold_acknowledge(cpu_bus_if_inst.hold_acknowledge),
    .ready_n(cpu_bus_if_inst.ready_n), .processor_clock(pclk));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  always #25 i_clk = ~i_clk;
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function automatic bit near(input int x, input int y);
    return x >= y - 1 && x <= y + 1;
  endfunction
  task automatic bus_op(input logic [2:0] c, input logic [23:0] a, input logic h,
                        input logic d, input logic m);
    int   n = 0;
    logic p = 1'b0;
    logic go = 1'b0;
    logic rd = 1'b0;
    int   na = 0;
    logic act = 1'b0;
    logic dr;
    logic [14:0] ex;
    seen = '0;
    rises = 0;
    tr = 0;
    tm = 0;
    tc = 0;
    i_code = c;
    i_addr = a;
    hbe_n = h;
    hlda = d;
    m16_n = m;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    while (o_done !== 1'b1 && n < 300) begin
      @(negedge i_clk);
      n++;
      if (go && !rd && !pclk && p) rises++;
      if (alep === 1'b1) na++;
      act |= mcyc;
      if (!(cpu_bus_if_inst.status_bit1_n & cpu_bus_if_inst.status_bit0_n)) go = 1'b1;
      p = pclk;
      if (cpu_bus_if_inst.ready_n === 1'b0) begin
        rd = 1'b1;
        wid = wid_o;
      end
      seen |= {rd && oe !== !d, ~row2_n, we0_n !== we1_n, ~we0_n, ~rom_n, ~col_strobe_high_n_n, ~col_strobe_low_n_n,
               ~row1_n, ~row0_n, halt, ~memory_write_cmd_n_n, ~memr_n, ~iow_n, ~ior_n, ~inta_n};
      if (tr == 0 && !(row0_n & row1_n)) tr = n;
      if (tm == 0 && mux) tm = n;
      if (tc == 0 && !(col_strobe_low_n_n & col_strobe_high_n_n)) tc = n;
    end
    dr = (c == 3'h5 || c == 3'h6) && !(h & a[0]) && (a < 24'h080000 ||
         (cfg == 2'h3 && a < 24'h0A0000));
    ex = {3'h0, c == 3'h6, !d && (a[23:17] == 7'h07 || a[23:17] == 7'h77 ||
          a[23:17] == 7'h7F), dr & !h, dr & !a[0], dr & a[19], dr & !a[19], c == 3'h4,
          c == 3'h6, c == 3'h5, c == 3'h2, c == 3'h1, c == 3'h0};
    chk(seen === ex,
      "strobe pattern");
    chk(!rd || wid === {h, a[0]}, "width");
    chk(!dr || (tr < tm && tm < tc), "dram order");
    chk(na === 1 && act === dr, "cycle start");
    chk({row0_n, row1_n, col_strobe_low_n_n, col_strobe_high_n_n, rom_n, memr_n, memory_write_cmd_n_n} === 7'h7F,
      "release");
  endtask
  task automatic measure(input int px);
    int k [6] = '{default: 0};
    logic [5:0] p = 6'h00;
    logic [5:0] v;
    for (int i = 0; i < 96; i++) begin
      @(negedge i_clk);
      v = {tclk, sclk, vclk, dclk, bclk, pclk};
      for (int j = 0; j < 6; j++) if (v[j] && !p[j]) k[j]++;
      p = v;
    end
    chk(near(k[0], px) && near(k[1], px / 2) && near(k[2], px / 4), "bus clocks");
    chk(near(k[3], 48) && near(k[4], 12) && near(k[5], 4),
      "osc clocks");
    chk(dcc === pclk, "controller clock");
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (8) @(negedge i_clk);
    chk(fast === 1'b1, "reset speed");
    chk(bclk === 1'b0 && dclk === 1'b0, "bus clock held");
    foreach (codes[i]) bus_op(codes[i], 24'h000100, 1'b0, 1'b0, 1'b1);
    measure(48);
    $display("test decode done");
    foreach (wt[i]) for (int j = 5; j < 7; j++)
      bus_op(3'(j), wt[i][23:0], wt[i][24], 1'b0, 1'b1);
    cfg = 2'h1;
    bus_op(3'h5, 24'h080000, 1'b0, 1'b0, 1'b1);
    cfg = 2'h3;
    foreach (rt[i]) bus_op(3'h5, rt[i], 1'b0, 1'b0, 1'b1);
    bus_op(3'h5, 24'hFE0000, 1'b0, 1'b1, 1'b1);
    $display("test memory done");
    bus_op(3'h5, 24'h0A0000, 1'b0, 1'b0, 1'b1);
    r8 = rises;
    bus_op(3'h5, 24'h0A0000, 1'b0, 1'b0, 1'b0);
    r16 = rises;
    chk(r8 - r16 === 3, "fast waits");
    spd = 1'b0;
    bus_op(3'h2, 24'h000062, 1'b0, 1'b0, 1'b1);
    spd = 1'b1;
    bus_op(3'h2, 24'h000063, 1'b0, 1'b0, 1'b1);
    chk(fast === 1'b0, "slow select");
    measure(24);
    bus_op(3'h1, 24'h0A0000, 1'b0, 1'b0, 1'b1);
    r8 = rises;
    bus_op(3'h5, 24'h0A0000, 1'b0, 1'b0, 1'b0);
    chk(r8 - rises === 1 && rises === r16, "slow waits");
    i_rstn = 1'b0;
    repeat (16) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (8) @(negedge i_clk);
    chk(fast === 1'b1 && bclk === 1'b0, "second reset");
    $display("test speed done");
    print_verdict();
  end
endmodule
